/* File: core/pgs_cfg.svh */
/*
 Offsets, reset values and pin placement for the port and pin
 steering block. Assumes an APB byte address of 8 bits.
*/
`ifndef PGS_CFG_SVH
`define PGS_CFG_SVH

// Register offsets inside one port, then the shared select registers; port B sits at PGS_PORTB
`define PGS_OFF_DIR   5'h00
`define PGS_OFF_LVL   5'h04
`define PGS_OFF_LAT   5'h08
`define PGS_OFF_ANS   5'h0c
`define PGS_OFF_WPU   5'h10
`define PGS_PORTB     8'h20
`define PGS_OFF_ALT0  8'h40
`define PGS_OFF_ALT1  8'h44

// Reset values
`define PGS_RST_DIR   8'hff
`define PGS_RST_LAT   8'h00
`define PGS_RST_ANS   8'hff
`define PGS_RST_WPU   8'h00
`define PGS_RST_ALT   8'h00
`define PGS_RST_OEN   8'hff

// Steered functions and their pins: A bits are 0..7, B bits 8..15
`define PGS_NFN       9
`define PGS_FN0_DEF   4'd11
`define PGS_FN0_ALT   4'd8
`define PGS_FN1_DEF   4'd14
`define PGS_FN1_ALT   4'd7
`define PGS_FN2_DEF   4'd15
`define PGS_FN2_ALT   4'd6
`define PGS_FN3_DEF   4'd14
`define PGS_FN3_ALT   4'd7
`define PGS_FN4_DEF   4'd15
`define PGS_FN4_ALT   4'd6
`define PGS_FN5_DEF   4'd13
`define PGS_FN5_ALT   4'd5
`define PGS_FN6_DEF   4'd10
`define PGS_FN6_ALT   4'd6
`define PGS_FN7_DEF   4'd9
`define PGS_FN7_ALT   4'd10
`define PGS_FN8_DEF   4'd10
`define PGS_FN8_ALT   4'd13

`endif

/* File: core/pgs_pkg.sv */
/*
 Types shared by the port and pin steering block.
 Assumes pgs_cfg.svh for all numeric constants.
*/
package pgs_pkg;
   typedef logic [7:0] pgs_byte_t;
   typedef logic [3:0] pgs_pin_t;
   typedef logic [8:0] pgs_fn_t;
   // Bus slave phases
   typedef enum logic [0:0] {PGS_IDLE, PGS_ACK} pgs_apb_st_t;
   // Decoded register
   typedef enum logic [2:0] {
      PGS_R_DIR, PGS_R_LVL, PGS_R_LAT, PGS_R_ANS,
      PGS_R_WPU, PGS_R_ALT0, PGS_R_ALT1, PGS_R_NONE
   } pgs_reg_t;
endpackage

/* File: core/pgs_port.sv */
/*
 Pin control for one 8-bit port: driver enable, drive value,
 pull-up and digital input. Purely combinational; the top
 registers every result.
*/
`timescale 1ns/1ps
module pgs_port (
   input  wire pgs_pkg::pgs_byte_t dir,
   input  wire pgs_pkg::pgs_byte_t lat,
   input  wire pgs_pkg::pgs_byte_t ans,
   input  wire pgs_pkg::pgs_byte_t wpu,
   input  wire pgs_pkg::pgs_byte_t own,
   input  wire pgs_pkg::pgs_byte_t drv,
   input  wire pgs_pkg::pgs_byte_t val,
   input  wire pgs_pkg::pgs_byte_t pin,
   output wire pgs_pkg::pgs_byte_t out,
   output wire pgs_pkg::pgs_byte_t oe_n,
   output wire pgs_pkg::pgs_byte_t pull,
   output wire pgs_pkg::pgs_byte_t dig
);
   import pgs_pkg::*;

   // An owning peripheral replaces direction and value
   assign oe_n = (own & ~drv) | (~own & dir);
   assign out  = (own & val) | (~own & lat);
   // Pull-up only while the driver is off
   assign pull = wpu & oe_n;
   // Analog pins read low and keep the buffer quiet
   assign dig  = pin & ~ans;
endmodule

/* File: core/pgs_route.sv */
/*
 Steering of nine peripheral functions onto sixteen pins.
 Assumes the select vector is {alt1 bit 0, alt0}.
*/
`timescale 1ns/1ps
`include "pgs_cfg.svh"
module pgs_route (
   input  wire pgs_pkg::pgs_fn_t sel,
   input  wire pgs_pkg::pgs_fn_t en,
   input  wire pgs_pkg::pgs_fn_t oe,
   input  wire pgs_pkg::pgs_fn_t dout,
   input  wire logic [15:0]      dig,
   output logic [15:0]           own,
   output logic [15:0]           drv,
   output logic [15:0]           val,
   output pgs_pkg::pgs_fn_t      fin
);
   import pgs_pkg::*;

   localparam pgs_pin_t DEF_T [`PGS_NFN] = '{`PGS_FN0_DEF, `PGS_FN1_DEF,
      `PGS_FN2_DEF, `PGS_FN3_DEF, `PGS_FN4_DEF, `PGS_FN5_DEF,
      `PGS_FN6_DEF, `PGS_FN7_DEF, `PGS_FN8_DEF};
   localparam pgs_pin_t ALT_T [`PGS_NFN] = '{`PGS_FN0_ALT, `PGS_FN1_ALT,
      `PGS_FN2_ALT, `PGS_FN3_ALT, `PGS_FN4_ALT, `PGS_FN5_ALT,
      `PGS_FN6_ALT, `PGS_FN7_ALT, `PGS_FN8_ALT};

   pgs_pin_t p;

   // Walk from lowest priority up so the lowest index wins a pin
   always_comb begin
      own = '0;
      drv = '0;
      val = '0;
      fin = '0;
      p   = '0;
      for (int f = `PGS_NFN - 1; f >= 0; f--) begin
         p = sel[f] ? ALT_T[f] : DEF_T[f];
         if (en[f]) begin
            own[p] = 1'b1;
            drv[p] = oe[f];
            val[p] = dout[f];
         end
         fin[f] = dig[p];
      end
   end
endmodule

/* File: core/pgs_top.sv */
/*
 Two general-purpose ports with alternate pin steering, reached
 over APB. Assumes pins and peripheral signals are synchronous to
 REF_CLK and that the master keeps APB signalling.
*/
`timescale 1ns/1ps
`include "pgs_cfg.svh"

// How it works
// - Two 8-bit ports, A and B, each with its own register set.
// - An enabled peripheral takes its pin away from the port.
// - Each port has direction, pin-level and output latch registers.
// - Writing the pin-level register loads the latch like a latch write.
// - Reading the latch register returns the latch contents.
// - Reading the pin-level register returns sampled pin levels.
// - Analog select turns off each pin's digital input buffer.
// - Select bits steer nine functions between two pins each.
// - Select writes never touch any direction register.
// - Peripheral direction and value follow the selected pin.
// - The unselected pin stays under plain port control.
// - Select 0 picks the default pin, 1 the alternate.
// - Direction 1 turns the driver off; 0 drives the latch.
// - Analog pins read 0 on every digital level read.
// - Port writes load the output latch whole; software does any read-modify-write.
// - Several owners on one pin: highest fixed priority wins.
module pgs_top (
   input  wire logic               REF_CLK,
   input  wire logic               RST,
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [7:0]         PADDR,
   input  wire logic [31:0]        PWDATA,
   output logic [31:0]             PRDATA,
   output logic                    PREADY,
   output logic                    PSLVERR,
   input  wire pgs_pkg::pgs_byte_t PA_IN,
   output pgs_pkg::pgs_byte_t      PA_OUT,
   output pgs_pkg::pgs_byte_t      PA_OE_N,
   output pgs_pkg::pgs_byte_t      PA_PULL,
   input  wire pgs_pkg::pgs_byte_t PB_IN,
   output pgs_pkg::pgs_byte_t      PB_OUT,
   output pgs_pkg::pgs_byte_t      PB_OE_N,
   output pgs_pkg::pgs_byte_t      PB_PULL,
   input  wire pgs_pkg::pgs_fn_t   FN_EN,
   input  wire pgs_pkg::pgs_fn_t   FN_OE,
   input  wire pgs_pkg::pgs_fn_t   FN_DOUT,
   output pgs_pkg::pgs_fn_t        FN_DIN
);
   import pgs_pkg::*;

   pgs_apb_st_t st_r;
   pgs_byte_t   dir_r [2];
   pgs_byte_t   lat_r [2];
   pgs_byte_t   ans_r [2];
   pgs_byte_t   wpu_r [2];
   pgs_byte_t   lvl_r [2];
   pgs_byte_t   alt0_r;
   logic        alt1_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   pgs_byte_t   pa_out_r;
   pgs_byte_t   pa_oen_r;
   pgs_byte_t   pa_pull_r;
   pgs_byte_t   pb_out_r;
   pgs_byte_t   pb_oen_r;
   pgs_byte_t   pb_pull_r;
   pgs_fn_t     fn_din_r;

   pgs_reg_t    reg_w;
   logic        port_w;
   logic        setup_w;
   logic        wr_go_w;
   logic [15:0] own_w;
   logic [15:0] drv_w;
   logic [15:0] val_w;
   pgs_fn_t     fin_w;
   pgs_byte_t   out_a;
   pgs_byte_t   oen_a;
   pgs_byte_t   pull_a;
   pgs_byte_t   dig_a;
   pgs_byte_t   out_b;
   pgs_byte_t   oen_b;
   pgs_byte_t   pull_b;
   pgs_byte_t   dig_b;

   // Address to register; port bit is PADDR[5]
   function automatic pgs_reg_t reg_of(input logic [7:0] a);
      if (a == `PGS_OFF_ALT0) begin
         return PGS_R_ALT0;
      end else if (a == `PGS_OFF_ALT1) begin
         return PGS_R_ALT1;
      end else if (a[7:6] != 2'b00) begin
         return PGS_R_NONE;
      end else if (a[4:0] == `PGS_OFF_DIR) begin
         return PGS_R_DIR;
      end else if (a[4:0] == `PGS_OFF_LVL) begin
         return PGS_R_LVL;
      end else if (a[4:0] == `PGS_OFF_LAT) begin
         return PGS_R_LAT;
      end else if (a[4:0] == `PGS_OFF_ANS) begin
         return PGS_R_ANS;
      end else if (a[4:0] == `PGS_OFF_WPU) begin
         return PGS_R_WPU;
      end else begin
         return PGS_R_NONE;
      end
   endfunction

   // Read value of one register, zero-extended to the bus
   function automatic logic [31:0] rd_of(input pgs_reg_t r, input logic p);
      logic [7:0] v;
      v = 8'h00;
      case (r)
         PGS_R_DIR:  v = dir_r[p];
         PGS_R_LVL:  v = lvl_r[p];
         PGS_R_LAT:  v = lat_r[p];
         PGS_R_ANS:  v = ans_r[p];
         PGS_R_WPU:  v = wpu_r[p];
         PGS_R_ALT0: v = alt0_r;
         PGS_R_ALT1: v = {7'h00, alt1_r};
         default:    v = 8'h00;
      endcase
      return {24'h000000, v};
   endfunction

   // Decode and bus phase qualifiers
   assign reg_w   = reg_of(PADDR);
   assign port_w  = PADDR[5];
   assign setup_w = PSEL && !PENABLE && (st_r == PGS_IDLE);
   assign wr_go_w = (st_r == PGS_ACK) && PSEL && PENABLE && PWRITE;

   // Bus phases: setup, then one access cycle with PREADY high
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st_r <= PGS_IDLE;
      end else begin
         case (st_r)
            PGS_IDLE: begin
               if (setup_w) begin
                  st_r <= PGS_ACK;
               end
            end
            default: begin
               st_r <= PGS_IDLE;
            end
         endcase
      end
   end

   // Answer is registered; read data is caught at the setup edge
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else if (setup_w) begin
         pready_r  <= 1'b1;
         pslverr_r <= (reg_w == PGS_R_NONE);
         prdata_r  <= PWRITE ? 32'h00000000 : rd_of(reg_w, port_w);
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end
   end

   // Port registers, one set per port
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < 2; i++) begin
            dir_r[i] <= `PGS_RST_DIR;
            lat_r[i] <= `PGS_RST_LAT;
            ans_r[i] <= `PGS_RST_ANS;
            wpu_r[i] <= `PGS_RST_WPU;
         end
      end else if (wr_go_w) begin
         if (reg_w == PGS_R_DIR) begin
            dir_r[port_w] <= PWDATA[7:0];
         end else if (reg_w == PGS_R_LVL || reg_w == PGS_R_LAT) begin
            // Software builds the new value from a level read
            lat_r[port_w] <= PWDATA[7:0];
         end else if (reg_w == PGS_R_ANS) begin
            ans_r[port_w] <= PWDATA[7:0];
         end else if (reg_w == PGS_R_WPU) begin
            wpu_r[port_w] <= PWDATA[7:0];
         end
      end
   end

   // Select bits live apart from the direction registers
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         alt0_r <= `PGS_RST_ALT;
         alt1_r <= 1'b0;
      end else if (wr_go_w && reg_w == PGS_R_ALT0) begin
         alt0_r <= PWDATA[7:0];
      end else if (wr_go_w && reg_w == PGS_R_ALT1) begin
         alt1_r <= PWDATA[0];
      end
   end

   // Function steering across both ports
   pgs_route u_route (
      .sel  ({alt1_r, alt0_r}),
      .en   (FN_EN),
      .oe   (FN_OE),
      .dout (FN_DOUT),
      .dig  ({dig_b, dig_a}),
      .own  (own_w),
      .drv  (drv_w),
      .val  (val_w),
      .fin  (fin_w)
   );

   // Per-port pin control; only owned pins see peripheral values
   pgs_port u_port_a (
      .dir  (dir_r[0]),
      .lat  (lat_r[0]),
      .ans  (ans_r[0]),
      .wpu  (wpu_r[0]),
      .own  (own_w[7:0]),
      .drv  (drv_w[7:0]),
      .val  (val_w[7:0]),
      .pin  (PA_IN),
      .out  (out_a),
      .oe_n (oen_a),
      .pull (pull_a),
      .dig  (dig_a)
   );

   pgs_port u_port_b (
      .dir  (dir_r[1]),
      .lat  (lat_r[1]),
      .ans  (ans_r[1]),
      .wpu  (wpu_r[1]),
      .own  (own_w[15:8]),
      .drv  (drv_w[15:8]),
      .val  (val_w[15:8]),
      .pin  (PB_IN),
      .out  (out_b),
      .oe_n (oen_b),
      .pull (pull_b),
      .dig  (dig_b)
   );

   // Pin levels sampled each cycle; reads see one cycle of lag
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         lvl_r[0] <= 8'h00;
         lvl_r[1] <= 8'h00;
         fn_din_r <= '0;
      end else begin
         lvl_r[0] <= dig_a;
         lvl_r[1] <= dig_b;
         fn_din_r <= fin_w;
      end
   end

   // Pin outputs registered so the pads never see decode glitches
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pa_out_r  <= 8'h00;
         pa_oen_r  <= `PGS_RST_OEN;
         pa_pull_r <= 8'h00;
         pb_out_r  <= 8'h00;
         pb_oen_r  <= `PGS_RST_OEN;
         pb_pull_r <= 8'h00;
      end else begin
         pa_out_r  <= out_a;
         pa_oen_r  <= oen_a;
         pa_pull_r <= pull_a;
         pb_out_r  <= out_b;
         pb_oen_r  <= oen_b;
         pb_pull_r <= pull_b;
      end
   end

   // Output ports straight from flops
   assign PRDATA  = prdata_r;
   assign PREADY  = pready_r;
   assign PSLVERR = pslverr_r;
   assign PA_OUT  = pa_out_r;
   assign PA_OE_N = pa_oen_r;
   assign PA_PULL = pa_pull_r;
   assign PB_OUT  = pb_out_r;
   assign PB_OE_N = pb_oen_r;
   assign PB_PULL = pb_pull_r;
   assign FN_DIN  = fn_din_r;

   // Checks on the design's own registers and outputs
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   chk_apb_ready_once: assert property (
      (PSEL && !PENABLE && st_r == PGS_IDLE) |=> PREADY ##1 !PREADY)
      else $error("PREADY not one cycle after setup");

   chk_lvl_write_latch: assert property (
      (wr_go_w && PADDR == 8'h04) |=> lat_r[0] == $past(PWDATA[7:0]))
      else $error("level write did not load latch A");

   chk_latch_readback: assert property (
      (setup_w && !PWRITE && PADDR == 8'h28)
      |=> PRDATA == {24'h000000, $past(lat_r[1])})
      else $error("latch B read mismatch");

   chk_level_readback: assert property (
      (setup_w && !PWRITE && PADDR == 8'h04)
      |=> PRDATA == {24'h000000, $past(lvl_r[0])})
      else $error("level A read mismatch");

   chk_analog_reads_zero: assert property (
      (lvl_r[1] & $past(ans_r[1])) == 8'h00)
      else $error("analog pin read high");

   chk_analog_fn_input: assert property (
      (!alt0_r[0] && ans_r[1][3]) |=> FN_DIN[0] == 1'b0)
      else $error("analog pin reached peripheral input");

   chk_alt_keeps_dir: assert property (
      (wr_go_w && PADDR == `PGS_OFF_ALT0)
      |=> ($stable(dir_r[0]) && $stable(dir_r[1])))
      else $error("select write changed direction");

   chk_gpio_follows_dir: assert property (
      1'b1 |=> ((PA_OE_N ^ $past(dir_r[0])) & ~$past(own_w[7:0])) == 8'h00)
      else $error("unowned pin A enable not from direction");

   chk_default_pin_drive: assert property (
      (FN_EN[0] && FN_OE[0] && !alt0_r[0])
      |=> (!PB_OE_N[3] && PB_OUT[3] == $past(FN_DOUT[0])))
      else $error("capture1 not driven on default pin");

   chk_alt_pin_drive: assert property (
      (FN_EN[0] && FN_OE[0] && alt0_r[0])
      |=> (!PB_OE_N[0] && PB_OUT[0] == $past(FN_DOUT[0])))
      else $error("capture1 not driven on alternate pin");

   chk_fn_input_route: assert property (
      1'b1 |=> FN_DIN[7] == $past(alt0_r[7] ? dig_b[2] : dig_b[1]))
      else $error("receive input from wrong pin");

   chk_pin_priority: assert property (
      (FN_EN[6] && FN_OE[6] && FN_EN[8] && FN_OE[8] && !alt0_r[6] && !alt1_r)
      |=> PB_OUT[2] == $past(FN_DOUT[6]))
      else $error("lower priority owner took the pin");

   chk_sel_reset_zero: assert property (
      $past(RST) |-> (alt0_r == 8'h00 && !alt1_r))
      else $error("select bits not clear after reset");

   chk_owner_takes_pin: assert property (
      (FN_EN[5] && !FN_OE[5] && alt0_r[5] && !(FN_EN[6] && alt0_r[6])
       && !(FN_EN[1] && alt0_r[1]) && !(FN_EN[2] && alt0_r[2]))
      |=> PA_OE_N[5])
      else $error("input function pin still driven");
endmodule

/* File: verification/pgs_pin_model.sv */
/*
 Board-side model of the eight package pins of one port.
 Assumes the bench sets an external level and enable per pin.
*/
`timescale 1ns/1ps
module pgs_pin_model (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire pgs_pkg::pgs_byte_t out,
   input  wire pgs_pkg::pgs_byte_t oe_n,
   input  wire pgs_pkg::pgs_byte_t pull,
   input  wire pgs_pkg::pgs_byte_t ext_val,
   input  wire pgs_pkg::pgs_byte_t ext_en,
   output pgs_pkg::pgs_byte_t      lvl
);
   import pgs_pkg::*;
   pgs_byte_t last_r;

   // Last level seen, so a floating pin can show its inverse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_r <= 8'h00;
      end else begin
         last_r <= lvl;
      end
   end

   // Driver first, then external source, then pull-up; an undriven pin flips so it never looks stable
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!oe_n[i]) begin
            lvl[i] = out[i];
         end else if (ext_en[i]) begin
            lvl[i] = ext_val[i];
         end else if (pull[i]) begin
            lvl[i] = 1'b1;
         end else begin
            lvl[i] = ~last_r[i];
         end
      end
   end
endmodule

/* File: verification/tb_pgs_top.sv */
/*
 Self-checking bench for the port and pin steering block.
 Assumes the pin model on both ports and APB with one wait-free access.
*/
`timescale 1ns/1ps
`include "pgs_cfg.svh"
module tb_pgs_top;
   import pgs_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   pgs_byte_t   pa_in, pb_in, pa_out, pb_out, pa_oen, pb_oen, pa_pull, pb_pull;
   pgs_byte_t   pa_x = 8'h00, pb_x = 8'h00, pa_xe = 8'h00, pb_xe = 8'h00;
   pgs_fn_t     fn_en = 9'h0, fn_oe = 9'h0, fn_do = 9'h0, fn_di;
   int          miscompares = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  b;
   logic [8:0]  sv;
   pgs_pin_t    pn;
   pgs_pin_t    def_t [9] = '{`PGS_FN0_DEF, `PGS_FN1_DEF, `PGS_FN2_DEF, `PGS_FN3_DEF, `PGS_FN4_DEF,
                              `PGS_FN5_DEF, `PGS_FN6_DEF, `PGS_FN7_DEF, `PGS_FN8_DEF};
   pgs_pin_t    alt_t [9] = '{`PGS_FN0_ALT, `PGS_FN1_ALT, `PGS_FN2_ALT, `PGS_FN3_ALT, `PGS_FN4_ALT,
                              `PGS_FN5_ALT, `PGS_FN6_ALT, `PGS_FN7_ALT, `PGS_FN8_ALT};

   // 40 MHz reference
   always #12.5 clk = ~clk;

   pgs_top DUT (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PA_IN(pa_in),
      .PA_OUT(pa_out), .PA_OE_N(pa_oen), .PA_PULL(pa_pull), .PB_IN(pb_in), .PB_OUT(pb_out),
      .PB_OE_N(pb_oen), .PB_PULL(pb_pull), .FN_EN(fn_en), .FN_OE(fn_oe), .FN_DOUT(fn_do), .FN_DIN(fn_di));
   pgs_pin_model pins_a (.clk(clk), .rst(rst), .out(pa_out), .oe_n(pa_oen), .pull(pa_pull),
      .ext_val(pa_x), .ext_en(pa_xe), .lvl(pa_in));
   pgs_pin_model pins_b (.clk(clk), .rst(rst), .out(pb_out), .oe_n(pb_oen), .pull(pb_pull),
      .ext_val(pb_x), .ext_en(pb_xe), .lvl(pb_in));

   // Verdict and end of run
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         $display("mismatch pready expected 1 seen %b", pready);
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp_reg(nm, e, rd);
   endtask

   // Pin results land one edge after their cause; three edges cover model and sampling
   task automatic settle;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int p = 0; p < 2; p++) begin
         b = p ? `PGS_PORTB : 8'h00;
         rdc("dir", b + `PGS_OFF_DIR, 32'hff);
         rdc("lat", b + `PGS_OFF_LAT, 32'h00);
         rdc("ans", b + `PGS_OFF_ANS, 32'hff);
         rdc("wpu", b + `PGS_OFF_WPU, 32'h00);
      end
      rdc("alt0", `PGS_OFF_ALT0, 32'h00);
      rdc("alt1", `PGS_OFF_ALT1, 32'h00);
      // Unmapped place answers with an error and zero data
      apb(1'b0, 8'h48, 32'h0);
      cmp_reg("slverr", 32'h1, {31'h0, err});
      cmp_reg("unmapped", 32'h0, rd);
      // Outside world drives the upper nibble of both ports
      pa_x <= 8'ha5;
      pb_x <= 8'ha5;
      pa_xe <= 8'hf0;
      pb_xe <= 8'hf0;
      for (int p = 0; p < 2; p++) begin
         b = p ? `PGS_PORTB : 8'h00;
         apb(1'b1, b + `PGS_OFF_ANS, 32'h00);
         apb(1'b1, b + `PGS_OFF_DIR, 32'hf0);
         apb(1'b1, b + `PGS_OFF_LAT, 32'h3c);
         apb(1'b1, b + `PGS_OFF_WPU, 32'hff);
         settle();
         cmp_pin("oe_n", 16'h00f0, {8'h00, p ? pb_oen : pa_oen});
         cmp_pin("pull", 16'h00f0, {8'h00, p ? pb_pull : pa_pull});
         cmp_pin("out", 16'h000c, {8'h00, (p ? pb_out : pa_out) & 8'h0f});
         rdc("level", b + `PGS_OFF_LVL, 32'hac);
         rdc("latch", b + `PGS_OFF_LAT, 32'h3c);
         apb(1'b1, b + `PGS_OFF_LVL, rd ^ 32'h01);
         rdc("latch rmw", b + `PGS_OFF_LAT, 32'h3d);
         apb(1'b1, b + `PGS_OFF_ANS, 32'hff);
         settle();
         rdc("analog level", b + `PGS_OFF_LVL, 32'h00);
      end
      // Both ports as inputs with cleared latches before steering
      for (int p = 0; p < 2; p++) begin
         b = p ? `PGS_PORTB : 8'h00;
         apb(1'b1, b + `PGS_OFF_DIR, 32'hff);
         apb(1'b1, b + `PGS_OFF_LAT, 32'h00);
         apb(1'b1, b + `PGS_OFF_ANS, 32'h00);
      end
      pa_xe <= 8'h00;
      pb_xe <= 8'h00;
      // Each function driving a 1 onto default then alternate pin
      for (int i = 0; i < 9; i++) begin
         for (int s = 0; s < 2; s++) begin
            sv = 9'(s) << i;
            apb(1'b1, `PGS_OFF_ALT0, {24'h0, sv[7:0]});
            apb(1'b1, `PGS_OFF_ALT1, {31'h0, sv[8]});
            fn_en <= 9'h1 << i;
            fn_oe <= 9'h1 << i;
            fn_do <= 9'h1 << i;
            settle();
            pn = s ? alt_t[i] : def_t[i];
            cmp_pin("oe_n steer", ~(16'h1 << pn), {pb_oen, pa_oen});
            cmp_pin("out steer", 16'h1 << pn, {pb_out, pa_out} & (16'h1 << pn));
         end
      end
      rdc("dir a kept", `PGS_OFF_DIR, 32'hff);
      // Serial receive reads its selected pin only
      pb_x <= 8'h02;
      pb_xe <= 8'h06;
      fn_en <= 9'h080;
      fn_oe <= 9'h000;
      apb(1'b1, `PGS_OFF_ALT1, 32'h0);
      apb(1'b1, `PGS_OFF_ALT0, 32'h00);
      settle();
      cmp_pin("rx default", 16'h1, {15'h0, fn_di[7]});
      apb(1'b1, `PGS_OFF_ALT0, 32'h80);
      settle();
      cmp_pin("rx alternate", 16'h0, {15'h0, fn_di[7]});
      cmp_pin("rx pin input", 16'h0006, {8'h00, pb_oen & 8'h06});
      // Two functions on one pin: the lower index wins
      apb(1'b1, `PGS_OFF_ALT0, 32'h00);
      fn_en <= 9'h00a;
      fn_oe <= 9'h00a;
      fn_do <= 9'h008;
      settle();
      cmp_pin("priority lo", 16'h0, {15'h0, pb_out[6]});
      fn_do <= 9'h002;
      settle();
      cmp_pin("priority hi", 16'h1, {15'h0, pb_out[6]});
      // Slave data out and serial clock share their default pin
      fn_en <= 9'h140;
      fn_oe <= 9'h140;
      fn_do <= 9'h040;
      settle();
      cmp_pin("priority spi", 16'h1, {15'h0, pb_out[2]});
      // An enabled function takes its pin away from a driving port
      apb(1'b1, `PGS_PORTB + `PGS_OFF_DIR, 32'h00);
      apb(1'b1, `PGS_PORTB + `PGS_OFF_LAT, 32'hff);
      fn_en <= 9'h004;
      fn_oe <= 9'h004;
      fn_do <= 9'h000;
      settle();
      cmp_pin("peripheral owns", 16'h007f, {8'h00, pb_out});
      rdc("dir b kept", `PGS_PORTB + `PGS_OFF_DIR, 32'h00);
      // An input function turns the port driver off on its alternate pin
      apb(1'b1, `PGS_OFF_DIR, 32'h00);
      fn_en <= 9'h020;
      fn_oe <= 9'h000;
      apb(1'b1, `PGS_OFF_ALT0, 32'h20);
      settle();
      cmp_pin("input owner", 16'h0020, {8'h00, pa_oen});
      // Reset in mid-run must put functions 0 to 7 back on their default pins and port B back to input
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc("alt0 after reset", `PGS_OFF_ALT0, 32'h00);
      rdc("dir b after reset", `PGS_PORTB + `PGS_OFF_DIR, 32'hff);
      finish_test();
   end
endmodule
